//--- pkg/ctaic_regs.svh
`ifndef CTAIC_REGS_SVH
`define CTAIC_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CTAIC_ADDR_ADC_CTL 8'h15
`define CTAIC_ADDR_ADC_DIS 8'h16
`define CTAIC_RST_ADC_CTL 8'h30
`define CTAIC_RST_ADC_DIS 8'h00
`define CTAIC_RDATA_UNMAPPED 8'hFF
`define CTAIC_ADC_EN_BIT 7
`define CTAIC_ADC_ONESHOT_BIT 6
`define CTAIC_ADC_SAMPLE_HI 5
`define CTAIC_ADC_SAMPLE_LO 4

// ----------------------------------------------------------------
// Interrupt source positions
// ----------------------------------------------------------------
`define CTAIC_IRQ_N 13
`define CTAIC_IRQ_PG 0
`define CTAIC_IRQ_VBUS_TYPE 1
`define CTAIC_IRQ_IINDPM 2
`define CTAIC_IRQ_INPUT_VOLTAGE_LOOP 3
`define CTAIC_IRQ_JUNCTION_TEMP_REGULATION 4
`define CTAIC_IRQ_WDOG 5
`define CTAIC_IRQ_CHRG 6
`define CTAIC_IRQ_TS 7
`define CTAIC_IRQ_VBUS_OV 8
`define CTAIC_IRQ_DIE_OVERHEAT_SHUTDOWN 9
`define CTAIC_IRQ_BATTERY_OVERVOLTAGE 10
`define CTAIC_IRQ_TMR 11
`define CTAIC_IRQ_ADC_DONE 12

// ----------------------------------------------------------------
// Charge phase codes
// ----------------------------------------------------------------
`define CTAIC_PH_IDLE 3'h0
`define CTAIC_PH_TRICKLE 3'h1
`define CTAIC_PH_PRECHG 3'h2
`define CTAIC_PH_FAST_CC 3'h3
`define CTAIC_PH_TAPER_CV 3'h4
`define CTAIC_PH_TOPOFF 3'h5
`define CTAIC_PH_DONE 3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CTAIC_CLK_MHZ 125
`define CTAIC_IRQ_PULSE_US 256
`define CTAIC_TICK_MS 1000
`define CTAIC_PRECHG_HOURS 2
`define CTAIC_SEC_PER_HOUR 3600

`endif

//--- pkg/ctaic_pkg.sv
`default_nettype none
package ctaic_pkg;

  // Levels from the analog side, all asynchronous to CLOCK
  typedef struct packed {
    logic ce_n;
    logic vbus_uvlo_ok;
    logic bat_uvlo_ok;
    logic vbus_ov;
    logic poor_source;
    logic src_det_done;
    logic adapter_present;
    logic bat_below_short;
    logic bat_below_lowv;
    logic rechg_below;
    logic input_voltage_loop;
    logic external_current_limit_pin_over;
    logic junction_temp_regulation;
    logic chg_fault;
    logic supplement;
    logic wdog_expired;
    logic die_overheat_shutdown;
    logic battery_overvoltage;
    logic cv_region;
    logic topoff_active;
    logic terminated;
    logic adc_conv_done;
    logic [2:0] thermistor_zone;
    logic [2:0] input_source_type;
  } ctaic_pins_t;

  // Host-written settings, already on CLOCK
  typedef struct packed {
    logic timer_enable;
    logic [1:0] fast_charge_duration_sel;
    logic slow_count_enable;
    logic charge_enable_bit;
    logic input_high_impedance;
    logic reverse_output_enable;
    logic external_limit_pin_enable;
  } ctaic_cfg_t;

  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_RUN,
    ADC_HOLD
  } ctaic_adc_st_t;

endpackage
`default_nettype wire

//--- logic/ctaic_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctaic_regs.svh"

module ctaic_top #(
  parameter int N_CH = 8,
  parameter int IRQ_PULSE_CYCLES = `CTAIC_IRQ_PULSE_US * `CTAIC_CLK_MHZ,
  parameter int TICK_CYCLES = `CTAIC_TICK_MS * 1000 * `CTAIC_CLK_MHZ,
  parameter int PRECHG_TICKS = `CTAIC_PRECHG_HOURS * `CTAIC_SEC_PER_HOUR,
  parameter int FAST_TICKS_0 = 5 * `CTAIC_SEC_PER_HOUR,
  parameter int FAST_TICKS_1 = 8 * `CTAIC_SEC_PER_HOUR,
  parameter int FAST_TICKS_2 = 12 * `CTAIC_SEC_PER_HOUR,
  parameter int FAST_TICKS_3 = 20 * `CTAIC_SEC_PER_HOUR
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic LINK_CLK,
  input wire ctaic_pkg::ctaic_pins_t PINS,
  input wire ctaic_pkg::ctaic_cfg_t CFG,
  input wire logic [`CTAIC_IRQ_N-1:0] IRQ_MASK,
  input wire logic [`CTAIC_IRQ_N-1:0] FLAG_READ,
  input wire logic REG_REQ,
  input wire logic REG_WRITE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic REG_BUSY,
  output logic REG_DONE,
  output logic [7:0] REG_RDATA,
  output logic INT_N,
  output logic SOURCE_GOOD_N_PIN,
  output logic [`CTAIC_IRQ_N-1:0] STATUS,
  output logic [`CTAIC_IRQ_N-1:0] FLAGS,
  output logic [2:0] CHARGE_PHASE,
  output logic EXT_LIMIT_MONITOR_EN,
  output logic ADC_START,
  output logic [$clog2(N_CH)-1:0] ADC_CHANNEL,
  output logic ADC_LATCH,
  output logic [1:0] ADC_SAMPLE_SPEED
);

  localparam int CHW = $clog2(N_CH);
  localparam int TW = 32;
  localparam int TICKW = $clog2(TICK_CYCLES + 1);
  localparam int PW = $clog2(IRQ_PULSE_CYCLES + 1);
  localparam int PINW = $bits(ctaic_pkg::ctaic_pins_t);

  generate
    if (N_CH < 2 || N_CH > 8) begin : g_bad_nch
      $error("N_CH must lie in 2..8");
    end
    if (TICK_CYCLES < 1 || IRQ_PULSE_CYCLES < 1) begin : g_bad_cnt
      $error("Counts must be at least one cycle");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PINW-1:0] pin_s1_r;
  logic [PINW-1:0] pin_s2_r;
  ctaic_pkg::ctaic_pins_t pin;
  ctaic_pkg::ctaic_pins_t pin_q_r;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_q_r <= '0;
    end else begin
      pin_s1_r <= PINS;
      pin_s2_r <= pin_s1_r;
      pin_q_r <= pin;
    end
  end
  assign pin = ctaic_pkg::ctaic_pins_t'(pin_s2_r);

  // ----------------------------------------------------------------
  // Register access from the link clock
  // ----------------------------------------------------------------
  // Hold registers stay stable while busy, so the CLOCK side may read them
  // once it sees the request toggle.
  logic lk_req_tgl_r;
  logic lk_wr_r;
  logic [7:0] lk_addr_r;
  logic [7:0] lk_wdata_r;
  logic lk_ack_s1_r;
  logic lk_ack_s2_r;
  logic lk_ack_s3_r;
  logic m_ack_tgl_r;
  logic [7:0] m_rdata_r;

  always_ff @(posedge LINK_CLK or negedge NRST) begin
    if (!NRST) begin
      lk_req_tgl_r <= 1'b0;
      lk_wr_r <= 1'b0;
      lk_addr_r <= 8'h00;
      lk_wdata_r <= 8'h00;
      lk_ack_s1_r <= 1'b0;
      lk_ack_s2_r <= 1'b0;
      lk_ack_s3_r <= 1'b0;
      REG_BUSY <= 1'b0;
      REG_DONE <= 1'b0;
      REG_RDATA <= 8'h00;
    end else begin
      lk_ack_s1_r <= m_ack_tgl_r;
      lk_ack_s2_r <= lk_ack_s1_r;
      lk_ack_s3_r <= lk_ack_s2_r;
      REG_DONE <= 1'b0;
      if (REG_REQ && !REG_BUSY) begin
        lk_wr_r <= REG_WRITE;
        lk_addr_r <= REG_ADDR;
        lk_wdata_r <= REG_WDATA;
        lk_req_tgl_r <= ~lk_req_tgl_r;
        REG_BUSY <= 1'b1;
      end else if (lk_ack_s2_r != lk_ack_s3_r) begin
        REG_RDATA <= m_rdata_r;
        REG_DONE <= 1'b1;
        REG_BUSY <= 1'b0;
      end
    end
  end

  logic m_req_s1_r;
  logic m_req_s2_r;
  logic m_req_s3_r;
  logic m_req;
  logic wr_ctl;
  logic [7:0] dis_r;
  logic [7:0] ctl_r;

  assign m_req = m_req_s2_r != m_req_s3_r;
  assign wr_ctl = m_req && lk_wr_r && (lk_addr_r == `CTAIC_ADDR_ADC_CTL);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      m_req_s1_r <= 1'b0;
      m_req_s2_r <= 1'b0;
      m_req_s3_r <= 1'b0;
      m_ack_tgl_r <= 1'b0;
      m_rdata_r <= 8'h00;
      dis_r <= `CTAIC_RST_ADC_DIS;
    end else begin
      m_req_s1_r <= lk_req_tgl_r;
      m_req_s2_r <= m_req_s1_r;
      m_req_s3_r <= m_req_s2_r;
      if (m_req) begin
        m_ack_tgl_r <= ~m_ack_tgl_r;
        unique case (lk_addr_r)
          `CTAIC_ADDR_ADC_CTL: m_rdata_r <= ctl_r;
          `CTAIC_ADDR_ADC_DIS: m_rdata_r <= dis_r;
          default: m_rdata_r <= `CTAIC_RDATA_UNMAPPED;
        endcase
        if (lk_wr_r && lk_addr_r == `CTAIC_ADDR_ADC_DIS) begin
          dis_r <= lk_wdata_r;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Safety timer
  // ----------------------------------------------------------------
  logic chg_active;
  logic chg_active_q_r;
  logic restart;
  logic iin_loop;
  logic slow;
  logic suspend;
  logic tick;
  logic half_r;
  logic [TICKW-1:0] tick_cnt_r;
  logic [TW-1:0] tmr_cnt_r;
  logic [TW-1:0] tmr_limit;
  logic tmr_fault_r;

  assign chg_active = CFG.charge_enable_bit && !pin.ce_n;
  assign restart = (chg_active && !chg_active_q_r)
    || (pin.rechg_below && !pin_q_r.rechg_below)
    || (pin.bat_below_lowv != pin_q_r.bat_below_lowv)
    || (pin.bat_below_short != pin_q_r.bat_below_short);
  assign iin_loop = (CFG.external_limit_pin_enable && pin.external_current_limit_pin_over);
  assign slow = CFG.slow_count_enable && (iin_loop
    || pin.input_voltage_loop || pin.junction_temp_regulation);
  assign suspend = pin.chg_fault || pin.supplement || !chg_active;
  assign tick = tick_cnt_r == TICKW'(TICK_CYCLES - 1);

  always_comb begin
    if (pin.bat_below_short) begin
      tmr_limit = TW'(PRECHG_TICKS);
    end else begin
      unique case (CFG.fast_charge_duration_sel)
        2'h0: tmr_limit = TW'(FAST_TICKS_0);
        2'h1: tmr_limit = TW'(FAST_TICKS_1);
        2'h2: tmr_limit = TW'(FAST_TICKS_2);
        2'h3: tmr_limit = TW'(FAST_TICKS_3);
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TICKW'(1);
    end
  end

  // Count is kept when the slow bit flips; only the stepping changes.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      chg_active_q_r <= 1'b0;
      half_r <= 1'b0;
      tmr_cnt_r <= '0;
      tmr_fault_r <= 1'b0;
    end else begin
      chg_active_q_r <= chg_active;
      if (!CFG.timer_enable || restart) begin
        tmr_cnt_r <= '0;
        half_r <= 1'b0;
        tmr_fault_r <= 1'b0;
      end else if (tick && !suspend && !tmr_fault_r) begin
        half_r <= slow ? ~half_r : 1'b0;
        if (!slow || half_r) begin
          tmr_cnt_r <= tmr_cnt_r + TW'(1);
          if (tmr_cnt_r + TW'(1) >= tmr_limit) begin
            tmr_fault_r <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // ADC sequencer
  // ----------------------------------------------------------------
  ctaic_pkg::ctaic_adc_st_t adc_st_r;
  logic [N_CH-1:0] live_mask;
  logic [N_CH-1:0] cyc_mask_r;
  logic [CHW-1:0] ch_r;
  logic adc_done_stat_r;
  logic pause_r;
  logic pause;
  logic mode_evt;
  logic conv_done;
  logic power_ok;
  logic adc_en;
  logic oneshot;
  logic first_ok;
  logic [CHW-1:0] first_ch;
  logic next_ok;
  logic [CHW-1:0] next_ch;
  logic ctl_hiz_q_r;
  logic ctl_otg_q_r;

  assign live_mask = ~dis_r[N_CH-1:0];
  assign adc_en = ctl_r[`CTAIC_ADC_EN_BIT];
  assign oneshot = ctl_r[`CTAIC_ADC_ONESHOT_BIT];
  assign power_ok = pin.vbus_uvlo_ok || pin.bat_uvlo_ok;
  assign conv_done = pin.adc_conv_done && !pin_q_r.adc_conv_done;
  assign mode_evt = (pin.adapter_present && !pin_q_r.adapter_present)
    || (CFG.input_high_impedance && !ctl_hiz_q_r)
    || (CFG.reverse_output_enable && !ctl_otg_q_r);
  // Faults do not stop conversion; only mode changes and detection pause it, and loss of power stops it.
  assign pause = pause_r || mode_evt
    || (pin.adapter_present && !pin.src_det_done);

  function automatic logic [CHW:0] pick(input logic [N_CH-1:0] m,
                                        input int from);
    logic [CHW:0] res;
    res = '0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (m[i] && i >= from) begin
        res = {1'b1, CHW'(i)};
      end
    end
    return res;
  endfunction

  assign {first_ok, first_ch} = pick(live_mask, 0);
  assign {next_ok, next_ch} = pick(cyc_mask_r, int'(ch_r) + 1);

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pause_r <= 1'b0;
      ctl_hiz_q_r <= 1'b0;
      ctl_otg_q_r <= 1'b0;
    end else begin
      ctl_hiz_q_r <= CFG.input_high_impedance;
      ctl_otg_q_r <= CFG.reverse_output_enable;
      if (mode_evt) begin
        pause_r <= 1'b1;
      end else if (pin.src_det_done || !pin.adapter_present) begin
        pause_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      adc_st_r <= ctaic_pkg::ADC_IDLE;
      ctl_r <= `CTAIC_RST_ADC_CTL;
      cyc_mask_r <= '0;
      ch_r <= '0;
      adc_done_stat_r <= 1'b0;
      ADC_START <= 1'b0;
      ADC_LATCH <= 1'b0;
      ADC_CHANNEL <= '0;
    end else begin
      ADC_START <= 1'b0;
      ADC_LATCH <= 1'b0;
      if (!oneshot) begin
        adc_done_stat_r <= 1'b0;
      end
      unique case (adc_st_r)
        ctaic_pkg::ADC_IDLE: begin
          if (adc_en && !power_ok) begin
            ctl_r[`CTAIC_ADC_EN_BIT] <= 1'b0;
          end else if (adc_en && !first_ok) begin
            if (oneshot) begin
              ctl_r[`CTAIC_ADC_EN_BIT] <= 1'b0;
            end
          end else if (adc_en && !pause) begin
            cyc_mask_r <= live_mask;
            ch_r <= first_ch;
            ADC_CHANNEL <= first_ch;
            ADC_START <= 1'b1;
            adc_done_stat_r <= 1'b0;
            adc_st_r <= ctaic_pkg::ADC_RUN;
          end
        end
        ctaic_pkg::ADC_RUN: begin
          if (!power_ok) begin
            ctl_r[`CTAIC_ADC_EN_BIT] <= 1'b0;
            adc_st_r <= ctaic_pkg::ADC_IDLE;
          end else if (pause) begin
            adc_st_r <= ctaic_pkg::ADC_HOLD;
          end else if (conv_done) begin
            ADC_LATCH <= 1'b1;
            if (next_ok) begin
              ch_r <= next_ch;
              ADC_CHANNEL <= next_ch;
              ADC_START <= 1'b1;
            end else begin
              adc_st_r <= ctaic_pkg::ADC_IDLE;
              if (oneshot) begin
                ctl_r[`CTAIC_ADC_EN_BIT] <= 1'b0;
                adc_done_stat_r <= 1'b1;
              end
            end
          end
        end
        ctaic_pkg::ADC_HOLD: begin
          if (!power_ok) begin
            ctl_r[`CTAIC_ADC_EN_BIT] <= 1'b0;
            adc_st_r <= ctaic_pkg::ADC_IDLE;
          end else if (!pause) begin
            ADC_CHANNEL <= ch_r;
            ADC_START <= 1'b1;
            adc_st_r <= ctaic_pkg::ADC_RUN;
          end
        end
      endcase
      // A host write wins; clearing the enable stops at once.
      if (wr_ctl) begin
        ctl_r <= lk_wdata_r;
        if (!lk_wdata_r[`CTAIC_ADC_EN_BIT]) begin
          ADC_START <= 1'b0;
          ADC_LATCH <= 1'b0;
          adc_st_r <= ctaic_pkg::ADC_IDLE;
        end
      end
    end
  end
  assign ADC_SAMPLE_SPEED = ctl_r[`CTAIC_ADC_SAMPLE_HI:`CTAIC_ADC_SAMPLE_LO];

  // ----------------------------------------------------------------
  // Status, flags and interrupt pulse
  // ----------------------------------------------------------------
  logic [`CTAIC_IRQ_N-1:0] stat;
  logic [`CTAIC_IRQ_N-1:0] stat_q_r;
  logic [`CTAIC_IRQ_N-1:0] evt;
  logic [2:0] phase;
  logic src_good;
  logic boot_r;
  logic [PW-1:0] pulse_cnt_r;

  assign src_good = pin.vbus_uvlo_ok && !pin.vbus_ov
    && !pin.poor_source && pin.src_det_done;

  always_comb begin
    if (!chg_active || tmr_fault_r) begin
      phase = `CTAIC_PH_IDLE;
    end else if (pin.terminated) begin
      phase = `CTAIC_PH_DONE;
    end else if (pin.topoff_active) begin
      phase = `CTAIC_PH_TOPOFF;
    end else if (pin.cv_region) begin
      phase = `CTAIC_PH_TAPER_CV;
    end else if (pin.bat_below_short) begin
      phase = `CTAIC_PH_TRICKLE;
    end else if (pin.bat_below_lowv) begin
      phase = `CTAIC_PH_PRECHG;
    end else begin
      phase = `CTAIC_PH_FAST_CC;
    end
  end

  always_comb begin
    stat = '0;
    stat[`CTAIC_IRQ_PG] = src_good;
    stat[`CTAIC_IRQ_VBUS_TYPE] = |pin.input_source_type;
    stat[`CTAIC_IRQ_IINDPM] = iin_loop;
    stat[`CTAIC_IRQ_INPUT_VOLTAGE_LOOP] = pin.input_voltage_loop;
    stat[`CTAIC_IRQ_JUNCTION_TEMP_REGULATION] = pin.junction_temp_regulation;
    stat[`CTAIC_IRQ_WDOG] = pin.wdog_expired;
    stat[`CTAIC_IRQ_CHRG] = |phase;
    stat[`CTAIC_IRQ_TS] = |pin.thermistor_zone;
    stat[`CTAIC_IRQ_VBUS_OV] = pin.vbus_ov;
    stat[`CTAIC_IRQ_DIE_OVERHEAT_SHUTDOWN] = pin.die_overheat_shutdown;
    stat[`CTAIC_IRQ_BATTERY_OVERVOLTAGE] = pin.battery_overvoltage;
    stat[`CTAIC_IRQ_TMR] = tmr_fault_r;
    stat[`CTAIC_IRQ_ADC_DONE] = adc_done_stat_r;
  end

  always_comb begin
    evt = stat & ~stat_q_r;
    evt[`CTAIC_IRQ_PG] = src_good != stat_q_r[`CTAIC_IRQ_PG];
    evt[`CTAIC_IRQ_VBUS_TYPE] = pin.input_source_type
      != pin_q_r.input_source_type;
    evt[`CTAIC_IRQ_CHRG] = phase != CHARGE_PHASE;
    evt[`CTAIC_IRQ_TS] = pin.thermistor_zone != pin_q_r.thermistor_zone;
    evt[`CTAIC_IRQ_WDOG] = evt[`CTAIC_IRQ_WDOG] || boot_r;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      stat_q_r <= '0;
      boot_r <= 1'b1;
      STATUS <= '0;
      FLAGS <= '0;
      CHARGE_PHASE <= `CTAIC_PH_IDLE;
      SOURCE_GOOD_N_PIN <= 1'b1;
      EXT_LIMIT_MONITOR_EN <= 1'b0;
    end else begin
      stat_q_r <= stat;
      boot_r <= 1'b0;
      STATUS <= stat;
      CHARGE_PHASE <= phase;
      SOURCE_GOOD_N_PIN <= !src_good;
      // Monitoring only meaningful outside the pin's own loop
      EXT_LIMIT_MONITOR_EN <= CFG.external_limit_pin_enable
        && !pin.external_current_limit_pin_over;
      FLAGS <= (FLAGS & ~FLAG_READ) | evt;
    end
  end

  // Events while the pulse runs are folded into it.
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pulse_cnt_r <= '0;
      INT_N <= 1'b1;
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - PW'(1);
      INT_N <= (pulse_cnt_r == PW'(1));
    end else if (|(evt & ~IRQ_MASK)) begin
      pulse_cnt_r <= PW'(IRQ_PULSE_CYCLES);
      INT_N <= 1'b0;
    end else begin
      INT_N <= 1'b1;
    end
  end

endmodule // ctaic_top
`default_nettype wire

//--- verification/ctaic_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------
// Host side of register port
// ----------------------------
module ctaic_host_model (
  input wire logic link_clk,
  input wire logic reg_busy,
  input wire logic reg_done,
  input wire logic [7:0] reg_rdata,
  output logic reg_req,
  output logic reg_write,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_req, reg_write, reg_addr, reg_wdata} = '0;
  // Request drops once busy is seen, else the port takes it twice
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge link_clk);
    reg_req <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    do @(posedge link_clk); while (reg_busy !== 1'b1 && ++n < 20);
    reg_req <= 1'b0;
    do @(posedge link_clk); while (reg_done !== 1'b1 && ++n < 40);
    q = reg_rdata;
  endtask
endmodule // ctaic_host_model
`default_nettype wire

//--- verification/ctaic_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctaic_regs.svh"
// ----------------------
// Port checker
// ----------------------
module ctaic_top_chk #(
  parameter int IRQ_PULSE_CYCLES = 32000
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire ctaic_pkg::ctaic_cfg_t CFG,
  input wire logic [`CTAIC_IRQ_N-1:0] IRQ_MASK,
  input wire logic [`CTAIC_IRQ_N-1:0] FLAG_READ,
  input wire logic INT_N,
  input wire logic SOURCE_GOOD_N_PIN,
  input wire logic [`CTAIC_IRQ_N-1:0] STATUS,
  input wire logic [`CTAIC_IRQ_N-1:0] FLAGS,
  input wire logic [2:0] CHARGE_PHASE,
  input wire logic EXT_LIMIT_MONITOR_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  int low_cnt;
  // Counter keeps the long pulse check off a huge repetition
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) low_cnt <= 0;
    else if (INT_N) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  pulse_len_a: assert property (
    $rose(INT_N) |-> low_cnt == IRQ_PULSE_CYCLES) else $error("pulse len");
  pulse_max_a: assert property (
    low_cnt <= IRQ_PULSE_CYCLES) else $error("pulse too long");
  pulse_flag_a: assert property (
    $fell(INT_N) |-> FLAGS != '0) else $error("pulse without flag");
  timer_irq_a: assert property (
    $rose(STATUS[`CTAIC_IRQ_TMR]) && !IRQ_MASK[`CTAIC_IRQ_TMR] |->
    ##[0:2] (!INT_N && FLAGS[`CTAIC_IRQ_TMR])) else $error("timer irq");
  mask_quiet_a: assert property (
    &IRQ_MASK && INT_N |=> INT_N) else $error("masked pulse");
  flag_clear_a: assert property (
    FLAG_READ[`CTAIC_IRQ_WDOG] && !STATUS[`CTAIC_IRQ_WDOG] && $stable(STATUS)
    |=> !FLAGS[`CTAIC_IRQ_WDOG]) else $error("flag not cleared");
  pg_pin_a: assert property (
    SOURCE_GOOD_N_PIN == !STATUS[`CTAIC_IRQ_PG]) else $error("pg pin");
  phase_code_a: assert property (
    CHARGE_PHASE <= 3'h6) else $error("phase code");
  limit_off_a: assert property (
    !CFG.external_limit_pin_enable |=> !EXT_LIMIT_MONITOR_EN)
    else $error("limit pin used");
  timer_off_a: assert property (
    !CFG.timer_enable [*3] |=> !STATUS[`CTAIC_IRQ_TMR]) else $error("tmr");
  cover property ($rose(INT_N));
  cover property ($rose(STATUS[`CTAIC_IRQ_TMR]));
  cover property (FLAG_READ != '0);
endmodule // ctaic_top_chk
bind ctaic_top ctaic_top_chk #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) chk_i (
  .CLOCK, .NRST, .CFG, .IRQ_MASK, .FLAG_READ, .INT_N, .SOURCE_GOOD_N_PIN,
  .STATUS, .FLAGS, .CHARGE_PHASE, .EXT_LIMIT_MONITOR_EN);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctaic_regs.svh"
// ----------------------
// Testbench
// ----------------------
module tb;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst;
  ctaic_pkg::ctaic_pins_t pins = '0;
  ctaic_pkg::ctaic_cfg_t cfg = '0;
  logic [12:0] mask = '0;
  logic [12:0] frd = '0;
  logic req, we, busy, done, int_n, pg_n, st;
  logic [7:0] addr, wd, rd, q;
  logic [12:0] status, flags;
  logic lat, lmon;
  logic [2:0] phase, chan;
  logic [1:0] spd;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int falls = 0;
  int starts = 0;
  int lats = 0;
  always #4 clk = ~clk;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  ctaic_top #(.IRQ_PULSE_CYCLES(8), .TICK_CYCLES(4), .PRECHG_TICKS(10),
    .FAST_TICKS_0(10), .FAST_TICKS_1(10), .FAST_TICKS_2(10),
    .FAST_TICKS_3(10)) dut (.CLOCK(clk), .NRST(nrst), .LINK_CLK(lclk),
    .PINS(pins), .CFG(cfg), .IRQ_MASK(mask), .FLAG_READ(frd),
    .REG_REQ(req), .REG_WRITE(we), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_BUSY(busy), .REG_DONE(done), .REG_RDATA(rd), .INT_N(int_n),
    .SOURCE_GOOD_N_PIN(pg_n), .STATUS(status), .FLAGS(flags),
    .CHARGE_PHASE(phase), .EXT_LIMIT_MONITOR_EN(lmon), .ADC_START(st),
    .ADC_CHANNEL(chan), .ADC_LATCH(lat), .ADC_SAMPLE_SPEED(spd));
  ctaic_host_model host (.link_clk(lclk), .reg_busy(busy), .reg_done(done),
    .reg_rdata(rd), .reg_req(req), .reg_write(we), .reg_addr(addr),
    .reg_wdata(wd));
  always @(negedge int_n) falls++;
  always @(posedge st) starts++;
  always @(posedge lat) lats++;
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs under a thousand cycles; a hang stops at cycle 20000
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdflag(input int b);
    @(posedge clk) frd[b] <= 1'b1;
    @(posedge clk) frd <= '0;
    wclk(2);
  endtask
  task automatic power(input logic on);
    @(posedge clk) begin
      pins.vbus_uvlo_ok <= on;
      pins.adapter_present <= on;
    end
    wclk(20);
  endtask
  task automatic t_regs();
    chk("boot flag", 8'h01, 8'(flags[`CTAIC_IRQ_WDOG]));
    rdflag(`CTAIC_IRQ_WDOG);
    chk("read flag", 8'h00, 8'(flags[`CTAIC_IRQ_WDOG]));
    host.xfer(1'b0, 8'h15, 8'h00, q);
    chk("ctl reset", 8'h30, q);
    host.xfer(1'b0, 8'h16, 8'h00, q);
    chk("dis reset", 8'h00, q);
    host.xfer(1'b1, 8'h40, 8'h12, q);
    host.xfer(1'b0, 8'h40, 8'h00, q);
    chk("unmapped", 8'hFF, q);
    host.xfer(1'b1, 8'h16, 8'hFA, q);
    host.xfer(1'b0, 8'h16, 8'h00, q);
    chk("dis write", 8'hFA, q);
  endtask
  // Channels 0 and 2 live; each conversion ends on a rising edge
  task automatic conv(input int k);
    repeat (k) begin
      @(posedge clk) pins.adc_conv_done <= 1'b1;
      wclk(6);
      pins.adc_conv_done <= 1'b0;
      wclk(6);
    end
  endtask
  task automatic t_adc();
    int s;
    int l;
    s = starts;
    l = lats;
    host.xfer(1'b1, 8'h15, 8'hF0, q);
    wclk(4);
    chk("adc start", 8'h01, 8'(starts - s));
    chk("sample speed", 8'h03, 8'(spd));
    conv(1);
    chk("next channel", 8'h02, 8'(chan));
    conv(1);
    chk("adc latch", 8'h02, 8'(lats - l));
    chk("done flag", 8'h01, 8'(flags[`CTAIC_IRQ_ADC_DONE]));
    host.xfer(1'b0, 8'h15, 8'h00, q);
    chk("oneshot end", 8'h70, q);
    rdflag(`CTAIC_IRQ_ADC_DONE);
    host.xfer(1'b1, 8'h15, 8'h80, q);
    conv(2);
    chk("cont done", 8'h00, 8'(flags[`CTAIC_IRQ_ADC_DONE]));
    host.xfer(1'b1, 8'h15, 8'h00, q);
    s = starts;
    conv(1);
    chk("adc halt", 8'h00, 8'(starts - s));
  endtask
  task automatic t_nopwr();
    int f;
    @(posedge clk) mask <= '1;
    rdflag(`CTAIC_IRQ_PG);
    f = falls;
    power(1'b0);
    chk("pg off", 8'h01, 8'(pg_n));
    chk("masked flag", 8'h01, 8'(flags[`CTAIC_IRQ_PG]));
    host.xfer(1'b1, 8'h15, 8'h80, q);
    host.xfer(1'b0, 8'h15, 8'h00, q);
    chk("nopwr en", 8'h00, q & 8'h80);
    chk("nopwr done", 8'h00, 8'(flags[`CTAIC_IRQ_ADC_DONE]));
    chk("masked irq", 8'h00, 8'(falls - f));
    @(posedge clk) mask <= '0;
  endtask
  task automatic t_tmr(input logic slow, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clk) begin
      cfg.timer_enable <= 1'b1;
      cfg.charge_enable_bit <= 1'b1;
      cfg.slow_count_enable <= slow;
      pins.input_voltage_loop <= slow;
    end
    while (status[`CTAIC_IRQ_TMR] !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      if (n == 10) chk("charging phase", 8'h03, 8'(phase));
    end
    chk("timer len", 8'h01, 8'(n >= lo && n <= hi));
    chk("fault phase", 8'h00, 8'(phase));
    @(posedge clk) begin
      cfg.timer_enable <= 1'b0;
      cfg.charge_enable_bit <= 1'b0;
    end
    wclk(5);
    chk("timer off", 8'h00, 8'(status[`CTAIC_IRQ_TMR]));
  endtask
  task automatic t_external_current_limit_pin();
    @(posedge clk) pins.external_current_limit_pin_over <= 1'b1;
    wclk(5);
    chk("pin off", 8'h00, 8'({status[`CTAIC_IRQ_IINDPM], lmon}));
    @(posedge clk) cfg.external_limit_pin_enable <= 1'b1;
    wclk(5);
    chk("pin loop", 8'h03, 8'({status[`CTAIC_IRQ_IINDPM],
      flags[`CTAIC_IRQ_IINDPM]}));
    @(posedge clk) pins.external_current_limit_pin_over <= 1'b0;
    wclk(5);
    chk("pin monitor", 8'h01, 8'(lmon));
  endtask
  task automatic t_rst();
    @(posedge clk) nrst <= 1'b0;
    wclk(3);
    nrst <= 1'b1;
    wclk(4);
    host.xfer(1'b0, 8'h16, 8'h00, q);
    chk("dis after reset", 8'h00, q);
  endtask
  initial begin
    nrst <= 1'b0;
    @(posedge clk) pins.src_det_done <= 1'b1;
    wclk(2);
    nrst <= 1'b1;
    wclk(4);
    t_regs();
    power(1'b1);
    chk("pg on", 8'h00, 8'(pg_n));
    t_adc();
    t_nopwr();
    power(1'b1);
    t_tmr(1'b0, 36, 52);
    t_tmr(1'b1, 76, 96);
    t_external_current_limit_pin();
    t_rst();
    close_out();
  end
endmodule // tb
`default_nettype wire
